// >>> solenoid_driver_spi_control.sv
// Function
// [R1] A transfer setup byte must precede any register data transfer.
// [R2] Register-select high for setup byte, low for register data.
// [R3] Register-select still high when chip select rises on setup.
// [R4] Setup byte stays in force for all later data transfers.
// [R5] Setup transfer shifts out the low state byte.
// [R6] Setup bit 7 picks read (0) or write (1).
// [R7] Setup bits 6 and 5 are written as zero.
// [R8] Setup bits 4..1 select the target bank.
// [R9] Setup bit 0 high: 8-bit top-byte transfers, else 32-bit.
// [R10] State top byte holds per-channel on bits, reset off.
// [R11] Bits 23..16 hold fault masks and master frequency select.
// [R12] Bits 15..8 hold pair configuration bits.
// [R13] Active bit resets to 0; while 0 all channels stay off.
// [R14] Low byte holds seven read-only summary fault flags.
// [R15] Undervoltage flag set at power-up, cleared by a state read.
// [R16] Host repeats programming when setup answer is 0x02.
// [R17] Host start-up: read, write state, write configs, read.
// [R18] Single-byte writes of on bits and hold byte apply at once.
// [R19] Mode and side bits change only with channels off, triggers low.
// [R20] Full config writes update slew and chop bits while running.
// [R21] Config layout: hold, hit, hit time, mode byte.
// [R22] Any unmasked fault drives the active-low alarm output.
// [R23] Link uses clock idle low, sampling on rising edges.
// [R24] Low config byte holds slew, open-load and hit-check enables.
// [R25] MSB first; reads return selected register, input ignored.
`timescale 1ns/1ns
`default_nettype none
module solenoid_driver_spi_control
  import solenoid_spi_pkg::*;
(
  input  wire logic                  clk,                // 50 MHz clock
  input  wire logic                  rst_b,              // Sync reset, low
  input  wire logic                  sck,                // Serial clock
  input  wire logic                  chip_select_n,      // Frame select
  input  wire logic                  reg_select,         // High: setup byte
  input  wire logic                  sdi,                // Serial data in
  output logic                       sdo,                // Serial data out
  input  wire logic                  ext_trigger_a,      // Trigger pin A
  input  wire logic                  ext_trigger_b,      // Trigger pin B
  input  wire logic                  fault_overtemp,     // Overtemp level
  input  wire logic [N_CH-1:0]       fault_overcurrent,  // Per channel
  input  wire logic [N_CH-1:0]       fault_open_load,    // Per channel
  input  wire logic [N_CH-1:0]       fault_hit_missed,   // Per channel
  input  wire logic [N_CH-1:0]       fault_plunger,      // Per channel
  input  wire logic                  undervoltage_event, // One-cycle pulse
  output logic [N_CH-1:0]            channel_on_out,     // Gated on bits
  output logic                       device_active,      // Active bit
  output logic [7:0]                 pair_config_bits,   // Pair setup
  output logic                       master_freq_select, // Osc select
  output logic [N_CH*WORD_W-1:0]     channel_config,     // All configs
  output logic                       alarm_out_n         // Fault, low
);
  typedef struct packed {
    logic                         cs_prev;
    logic                         have_cmd;
    logic [CMD_W-1:0]             cmd;
    logic [7:0]                   on;
    logic [7:0]                   mask;
    logic [7:0]                   pair;
    logic                         active;
    logic                         undervoltage_flag;
    logic                         comm_error_flag;
    logic                         alarm_n;
    logic [N_CH-1:0]              on_out;
    logic [N_CH-1:0][WORD_W-1:0]  cfg;
    logic [WORD_W-1:0]            tx;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [3:0]             pin_s;
  logic                   cs_s;
  logic                   sel_s;
  logic                   trig_a_s;
  logic                   trig_b_s;
  logic [WORD_W-1:0]      rx_q;
  logic [CNT_W-1:0]       cnt_q;
  logic                   sdo_n_q;
  logic                   link_clr;
  logic                   frame_end;
  logic                   cmd_wr;
  logic                   cmd_short;
  logic [3:0]             cmd_bank;
  logic [CNT_W-1:0]       cmd_len;
  logic                   unlock;
  logic                   st_rd;
  logic                   comm_error_flag_set;
  logic                   cfg_full_wr;
  logic [2:0]             cfg_idx;

  bit_sync #(.WIDTH(4), .RST_VAL(4'h3)) u_pin_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({ext_trigger_b, ext_trigger_a, reg_select, chip_select_n}),
    .dout  (pin_s)
  );
  assign cs_s     = pin_s[0];
  assign sel_s    = pin_s[1];
  assign trig_a_s = pin_s[2];
  assign trig_b_s = pin_s[3];

  // Link side is cleared while the frame is idle, from a clk flop
  assign link_clr = s_q.cs_prev;

  // [R23] rising-edge sampling
  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      cnt_q <= '0;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // [R25] MSB-first receive
  always_ff @(posedge sck) begin
    rx_q <= {rx_q[WORD_W-2:0], sdi};
  end

  // [R25] MSB-first transmit on falling edges
  always_ff @(negedge sck or posedge link_clr) begin
    if (link_clr) begin
      sdo_n_q <= 1'b0;
    end else if (cnt_q < LEN_LONG) begin
      sdo_n_q <= s_q.tx[5'(WORD_W - 1 - int'(cnt_q))];
    end else begin
      sdo_n_q <= 1'b0;
    end
  end

  // First bit must be valid before the first rising edge
  assign sdo = (cnt_q == '0) ? s_q.tx[WORD_W-1] : sdo_n_q;

  function automatic logic [7:0] flag_byte(input state_t s,
                                           input logic   overtemp_flag,
                                           input logic   overcurrent_flag,
                                           input logic   open_load_flag,
                                           input logic   hit_missed_flag,
                                           input logic   plunger_motion_flag);
    logic [7:0] f;
    f            = 8'h00;
    f[ST_ACTIVE] = s.active;
    f[ST_COMM_ERROR_FLAG]  = s.comm_error_flag;
    f[ST_UVM]    = s.undervoltage_flag;
    f[ST_DPM]    = plunger_motion_flag;
    f[ST_HHF]    = hit_missed_flag;
    f[ST_OLF]    = open_load_flag;
    f[ST_OCP]    = overcurrent_flag;
    f[ST_OVT]    = overtemp_flag;
    return f;
  endfunction

  logic [7:0]        flags;
  logic [WORD_W-1:0] status_word;
  logic [WORD_W-1:0] sel_word;

  // [R14] summary flags
  assign flags = flag_byte(s_q, fault_overtemp, |fault_overcurrent,
                           |fault_open_load, |fault_hit_missed,
                           |fault_plunger);
  assign status_word = {s_q.on, s_q.mask, s_q.pair, flags};

  // [R6] [R8] [R9] decode of the held setup byte
  assign cmd_wr    = s_q.cmd[CMD_RW_BIT];
  assign cmd_short = s_q.cmd[CMD_SHORT_BIT];
  assign cmd_bank  = s_q.cmd[CMD_BANK_HI:CMD_BANK_LO];
  assign cmd_len   = cmd_short ? LEN_SHORT : LEN_LONG;
  assign cfg_idx   = 3'(cmd_bank - BANK_CFG_FIRST);

  always_comb begin
    if (cmd_bank == BANK_STATUS) begin
      sel_word = status_word;
    end else if (cmd_bank >= BANK_CFG_FIRST && cmd_bank <= BANK_CFG_LAST) begin
      sel_word = s_q.cfg[cfg_idx];
    end else begin
      sel_word = '0;
    end
  end

  assign frame_end = cs_s && !s_q.cs_prev;
  // [R19] mode lock condition
  assign unlock    = (s_q.on == BYTE_RST) && !trig_a_s && !trig_b_s;

  always_comb begin
    s_d         = s_q;
    st_rd       = 1'b0;
    comm_error_flag_set   = 1'b0;
    cfg_full_wr = 1'b0;
    s_d.cs_prev = cs_s;
    if (frame_end) begin
      if (sel_s) begin
        // [R3] setup taken when select is high at frame end
        if (cnt_q == LEN_SHORT) begin
          s_d.cmd      = rx_q[CMD_W-1:0];
          s_d.have_cmd = 1'b1;
        end else begin
          comm_error_flag_set = 1'b1;
        end
      // [R1] [R4] data frames follow the held setup byte
      end else if (!s_q.have_cmd || cnt_q != cmd_len) begin
        comm_error_flag_set = 1'b1;
      end else if (!cmd_wr) begin
        st_rd = (cmd_bank == BANK_STATUS);
      end else if (cmd_bank == BANK_STATUS) begin
        // [R10] [R18] on bits, short or full
        if (cmd_short) begin
          s_d.on = rx_q[7:0];
        end else begin
          // [R11] [R12] masks, freq, pairs
          s_d.on     = rx_q[ST_ON_LO +: 8];
          s_d.mask   = rx_q[ST_MASK_LO +: 8];
          s_d.pair   = rx_q[ST_PAIR_LO +: 8];
          s_d.active = rx_q[ST_FLAG_LO + ST_ACTIVE];
        end
      end else if (cmd_bank >= BANK_CFG_FIRST &&
                   cmd_bank <= BANK_CFG_LAST) begin
        // [R21] [R18] hold byte alone or full word
        if (cmd_short) begin
          s_d.cfg[cfg_idx][CFG_TOP_LO +: 8] = rx_q[7:0];
        end else begin
          // [R20] [R24] full write applies while running
          cfg_full_wr     = 1'b1;
          s_d.cfg[cfg_idx] = rx_q;
          if (!unlock) begin
            s_d.cfg[cfg_idx][CFG_REG_MODE] = s_q.cfg[cfg_idx][CFG_REG_MODE];
            s_d.cfg[cfg_idx][CFG_HS_LS]    = s_q.cfg[cfg_idx][CFG_HS_LS];
          end
        end
      end
    end
    // [R15] set wins over the read clear
    s_d.undervoltage_flag   = (s_q.undervoltage_flag & ~st_rd) | undervoltage_event;
    s_d.comm_error_flag = (s_q.comm_error_flag & ~st_rd) | comm_error_flag_set;
    // [R22] unmasked faults drive the alarm
    s_d.alarm_n = ~|(flags[7:1] & ~s_q.mask[7:1]);
    // [R13] outputs off while inactive
    s_d.on_out = s_q.active ? s_q.on : BYTE_RST;
    // [R5] [R25] answer word, frozen while the frame runs
    if (cs_s) begin
      if (sel_s) begin
        s_d.tx = {flags, 24'h000000};
      end else if (cmd_wr) begin
        s_d.tx = '0;
      end else if (cmd_short) begin
        s_d.tx = {sel_word[WORD_W-1 -: 8], 24'h000000};
      end else begin
        s_d.tx = sel_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q         <= '0;
      s_q.cs_prev <= 1'b1;
      // [R15] undervoltage flagged at power-up
      s_q.undervoltage_flag     <= 1'b1;
      s_q.alarm_n <= 1'b0;
      s_q.cfg     <= {N_CH{CFG_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign channel_on_out     = s_q.on_out;
  assign device_active      = s_q.active;
  assign pair_config_bits   = s_q.pair;
  assign master_freq_select = s_q.mask[MSK_MASTER_FREQ_SELECT];
  assign channel_config     = s_q.cfg;
  assign alarm_out_n        = s_q.alarm_n;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence setup_frame_s;
    frame_end && sel_s && cnt_q == LEN_SHORT;
  endsequence

  sequence data_frame_s;
    frame_end && !sel_s && s_q.have_cmd && cnt_q == cmd_len;
  endsequence

  setup_capture_a: assert property ( // [R4]
    setup_frame_s |=> s_q.have_cmd && s_q.cmd == $past(rx_q[7:0]))
    else $error("setup byte not captured");

  bad_length_a: assert property ( // [R1]
    frame_end && (!sel_s && !s_q.have_cmd || sel_s && cnt_q != LEN_SHORT)
    |=> s_q.comm_error_flag && $stable(s_q.cfg) && $stable(s_q.on))
    else $error("bad frame not flagged");

  uv_clear_a: assert property ( // [R15]
    data_frame_s ##0 (!cmd_wr && cmd_bank == BANK_STATUS &&
    !undervoltage_event) |=> !s_q.undervoltage_flag)
    else $error("state read did not clear undervoltage");

  inactive_off_a: assert property ( // [R13]
    !s_q.active |=> channel_on_out == 8'h00)
    else $error("channel on while inactive");

  alarm_drive_a: assert property ( // [R22]
    (|(flags[7:1] & ~s_q.mask[7:1])) |=> !alarm_out_n)
    else $error("unmasked fault without alarm");

  mode_lock_a: assert property ( // [R19]
    !unlock |=> $stable(s_q.cfg[0][CFG_REG_MODE]) &&
    $stable(s_q.cfg[0][CFG_HS_LS]))
    else $error("mode bit changed while locked");

  short_status_a: assert property ( // [R18]
    data_frame_s ##0 (cmd_wr && cmd_short && cmd_bank == BANK_STATUS)
    |=> s_q.on == $past(rx_q[7:0]) && $stable(s_q.mask) &&
    $stable(s_q.active))
    else $error("short write touched more than on bits");

  full_cfg_a: assert property ( // [R20]
    cfg_full_wr |=> s_q.cfg[$past(cfg_idx)][CFG_SLEW:CFG_HIT_EN] ==
    $past(rx_q[CFG_SLEW:CFG_HIT_EN]))
    else $error("full config write not applied");

  setup_answer_a: assert property ( // [R5]
    cs_s && sel_s |=> s_q.tx[WORD_W-1 -: 8] == $past(flags))
    else $error("setup answer is not the flag byte");
endmodule
`default_nettype wire

// >>> solenoid_spi_pkg.sv
`default_nettype none
package solenoid_spi_pkg;
  localparam int N_CH   = 8;
  localparam int WORD_W = 32;
  localparam int CMD_W  = 8;
  localparam int CNT_W  = 6;

  // Transfer setup byte fields
  localparam int CMD_RW_BIT    = 7;
  localparam int CMD_BANK_HI   = 4;
  localparam int CMD_BANK_LO   = 1;
  localparam int CMD_SHORT_BIT = 0;

  // Bank codes
  localparam logic [3:0] BANK_STATUS   = 4'h0;
  localparam logic [3:0] BANK_CFG_FIRST = 4'h1;
  localparam logic [3:0] BANK_CFG_LAST  = 4'h8;

  // Transfer lengths in bits
  localparam logic [CNT_W-1:0] LEN_SHORT = 6'h08;
  localparam logic [CNT_W-1:0] LEN_LONG  = 6'h20;

  // Device state register byte positions
  localparam int ST_ON_LO   = 24;
  localparam int ST_MASK_LO = 16;
  localparam int ST_PAIR_LO = 8;
  localparam int ST_FLAG_LO = 0;

  // Low byte bits; mask byte bit i masks flag bit i, mask bit 0 is freq
  localparam int ST_ACTIVE = 0;
  localparam int ST_COMM_ERROR_FLAG  = 1;
  localparam int ST_UVM    = 2;
  localparam int ST_DPM    = 3;
  localparam int ST_HHF    = 4;
  localparam int ST_OLF    = 5;
  localparam int ST_OCP    = 6;
  localparam int ST_OVT    = 7;
  localparam int MSK_MASTER_FREQ_SELECT = 0;

  // Channel configuration low byte bits and hold (top) byte position
  localparam int CFG_REG_MODE = 7;
  localparam int CFG_HS_LS    = 6;
  localparam int CFG_CHOP_HI  = 5;
  localparam int CFG_CHOP_LO  = 4;
  localparam int CFG_SLEW     = 3;
  localparam int CFG_OPEN_LOAD_DETECT_ENABLE    = 2;
  localparam int CFG_HIT_EN   = 1;
  localparam int CFG_TOP_LO   = 24;

  localparam logic [WORD_W-1:0] CFG_RST  = 32'h0000_0000;
  localparam logic [7:0]        BYTE_RST = 8'h00;
endpackage
`default_nettype wire

// >>> bit_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,    // Destination clock
  input  wire logic             rst_b,  // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] din,    // Asynchronous levels
  output logic      [WIDTH-1:0] dout    // Synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  always_comb begin
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;
endmodule
`default_nettype wire

// >>> spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  output logic        sck,           // Link clock, idles low
  output logic        chip_select_n, // Frame select
  output logic        reg_select,    // High for setup frames
  output logic        sdi,           // Data to device
  input  wire logic   sdo,           // Data from device
  output logic [31:0] rx_word,       // Bits seen on sdo
  output logic        rx_done        // Pulse per checked frame
);
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    reg_select = 1'b0;
    sdi = 1'b0;
    rx_word = 32'h0;
    rx_done = 1'b0;
  end

  task automatic xfer(input logic sel, input int n,
                      input logic [31:0] d, input logic chk);
    logic [31:0] w;
    w = 32'h0;
    reg_select = sel;
    #100;
    chip_select_n = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = d[i];
      #62;
      w = {w[30:0], sdo};
      sck = 1'b1;
      #63;
      sck = 1'b0;
    end
    #60;
    chip_select_n = 1'b1;
    // Released line shows no stale bit
    sdi = ~sdi;
    #200;
    if (chk) begin
      rx_word = w;
      rx_done = 1'b1;
      #1;
      rx_done = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> solenoid_driver_spi_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module solenoid_driver_spi_control_bench import solenoid_spi_pkg::*;;
  logic clk, rst_b, sck, chip_select_n, reg_select, sdi, sdo, rx_done;
  logic ext_trigger_a, ext_trigger_b, fault_overtemp, undervoltage_event;
  logic [N_CH-1:0] fault_overcurrent, fault_open_load, fault_hit_missed;
  logic [N_CH-1:0] fault_plunger, channel_on_out;
  logic device_active, master_freq_select, alarm_out_n;
  logic [7:0] pair_config_bits, pair, on_e, msk_e;
  logic [N_CH*WORD_W-1:0] channel_config;
  logic [31:0] rx_word, rnd;
  logic [31:0] cfg_exp [N_CH];
  logic [31:0] exp_q [$];
  int checks, fails, cyc;

  spi_host_model host (.sck, .chip_select_n, .reg_select, .sdi, .sdo,
    .rx_word, .rx_done);
  solenoid_driver_spi_control dut (.clk, .rst_b, .sck, .chip_select_n,
    .reg_select, .sdi, .sdo, .ext_trigger_a, .ext_trigger_b,
    .fault_overtemp, .fault_overcurrent, .fault_open_load,
    .fault_hit_missed, .fault_plunger, .undervoltage_event,
    .channel_on_out, .device_active, .pair_config_bits,
    .master_freq_select, .channel_config, .alarm_out_n);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] st(input logic [7:0] f);
    return {on_e, msk_e, pair, f};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic setup(input logic [7:0] c, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    host.xfer(1'b1, 8, {24'h0, c}, 1'b1);
  endtask

  // Read frames carry random sdi, which must be ignored
  task automatic rd(input int n, input logic [31:0] e);
    exp_q.push_back(e);
    rnd = lfsr(rnd);
    host.xfer(1'b0, n, rnd, 1'b1);
  endtask

  task automatic wr(input int n, input logic [31:0] d);
    host.xfer(1'b0, n, d, 1'b0);
  endtask

  task give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge rx_done) chk("sdo", exp_q.pop_front(), rx_word);

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    rnd = 32'h40;
    {rst_b, ext_trigger_a, ext_trigger_b, fault_overtemp} = 4'h0;
    {fault_overcurrent, fault_open_load, fault_hit_missed} = 24'h0;
    {fault_plunger, undervoltage_event} = 9'h0;
    {on_e, msk_e, pair} = 24'h0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk("reset", 32'h0, {channel_on_out, device_active, alarm_out_n});
    wr(32, rnd);
    setup(8'h00, 8'h06);
    rd(32, st(8'h06));
    chk("alarm", 32'h1, alarm_out_n);
    rnd = lfsr(rnd);
    pair = rnd[15:8];
    on_e = 8'ha5;
    setup(8'h80, 8'h00);
    wr(32, {on_e, msk_e, pair, rnd[7:1], 1'b1});
    chk("on", {on_e, 1'b1, pair},
        {channel_on_out, device_active, pair_config_bits});
    setup(8'h00, 8'h01);
    rd(32, st(8'h01));
    rd(32, st(8'h01));
    for (int c = 0; c < N_CH; c++) begin
      rnd = lfsr(rnd);
      cfg_exp[c] = {rnd[31:8], 2'b00, rnd[5:0]};
      setup({3'h4, 4'(c + 1), 1'b0}, 8'h01);
      wr(32, rnd);
      chk("cfg", cfg_exp[c], channel_config[c*WORD_W +: WORD_W]);
      setup({3'h0, 4'(c + 1), 1'b0}, 8'h01);
      rd(32, cfg_exp[c]);
    end
    setup(8'h81, 8'h01);
    on_e = 8'h00;
    wr(8, 32'h0);
    chk("on", 32'h0, channel_on_out);
    setup(8'h01, 8'h01);
    rd(8, 32'h0);
    rnd = lfsr(rnd);
    setup(8'h87, 8'h01);
    wr(8, {24'h0, rnd[7:0]});
    cfg_exp[2][31:24] = rnd[7:0];
    chk("top", cfg_exp[2], channel_config[2*WORD_W +: WORD_W]);
    setup(8'h84, 8'h01);
    cfg_exp[1] = cfg_exp[1] | 32'hc0;
    wr(32, cfg_exp[1]);
    chk("mode", cfg_exp[1], channel_config[WORD_W +: WORD_W]);
    for (int t = 1; t < 3; t++) begin
      @(negedge clk);
      {ext_trigger_b, ext_trigger_a} = 2'(t);
      wr(32, cfg_exp[1] & ~32'hc0);
      chk("lock", cfg_exp[1], channel_config[WORD_W +: WORD_W]);
    end
    @(negedge clk);
    {ext_trigger_b, ext_trigger_a} = 2'h0;
    setup(8'h92, 8'h01);
    wr(32, rnd);
    setup(8'h12, 8'h01);
    rd(32, 32'h0);
    host.xfer(1'b0, 16, rnd, 1'b0);
    setup(8'h00, 8'h03);
    rd(32, st(8'h03));
    for (int k = 0; k < 5; k++) begin
      @(negedge clk);
      {fault_overtemp, fault_overcurrent[3], fault_open_load[3],
       fault_hit_missed[3], fault_plunger[3]} = 5'h10 >> k;
      repeat (3) @(negedge clk);
      chk("alarm", 32'h0, alarm_out_n);
      setup(8'h00, 8'h80 >> k | 8'h01);
    end
    @(negedge clk);
    {fault_overtemp, fault_plunger} = 9'h0;
    undervoltage_event = 1'b1;
    @(negedge clk);
    undervoltage_event = 1'b0;
    setup(8'h00, 8'h05);
    rd(32, st(8'h05));
    chk("alarm", 32'h1, alarm_out_n);
    msk_e = 8'h41;
    setup(8'h80, 8'h01);
    wr(32, st(8'h01));
    @(negedge clk);
    fault_overcurrent = 8'h01;
    repeat (3) @(negedge clk);
    chk("mask", 32'h3, {alarm_out_n, master_freq_select});
    fault_overcurrent = 8'h00;
    give_verdict();
  end
endmodule
`default_nettype wire
